// *** src/jtm_regs.svh ***
`ifndef JTM_REGS_SVH
`define JTM_REGS_SVH
// link mode codes
`define JTM_MODE_ZERO      4'h0
// lane frame layout: 16 nibbles, 5 samples of 12 bits then a tail nibble
`define JTM_FRAME_NIBBLES  16
`define JTM_FRAME_OCTETS   8
`define JTM_SLOTS          5
`define JTM_SLOT_BITS      12
`define JTM_LANES_USED_M0  4'h8
`define JTM_LANES_M0_DUAL  4'h4
`define JTM_LANES_M0_SINGLE 4'h2
// 64b/66b frames-per-multiframe factors
`define JTM_K_OCTETS       8
`define JTM_K_BLOCKS       32
// reset values
`define JTM_RST_OCTET      3'h0
`define JTM_RST_DATA       8'h00
`endif

// *** src/jtm_pkg.sv ***
package jtm_pkg;
  typedef enum logic [1:0] {JTM_IDLE, JTM_SEND} jtm_state_t;
  typedef enum logic [1:0] {JTM_QUAD, JTM_DUAL, JTM_SINGLE} jtm_variant_t;
endpackage

// *** src/jtm_lane_frame.sv ***
`timescale 1ns/1ps
`include "jtm_regs.svh"
// one lane's frame: five samples packed msb first, lsbs padded, tail nibble zero
module jtm_lane_frame #(
  parameter int RES = 9
) (
  // samples, oldest in the low bits
  input  wire logic [5*RES-1:0] samples,
  // packed 64-bit frame, octet 0 in the top byte
  output logic      [63:0]      frame
);
  function automatic logic [`JTM_SLOT_BITS-1:0] pad(input logic [RES-1:0] s);
    pad = {s, {(`JTM_SLOT_BITS-RES){1'b0}}};
  endfunction
  always_comb begin
    frame = 64'h0;
    for (int i = 0; i < `JTM_SLOTS; i++) begin
      frame[63-i*`JTM_SLOT_BITS -: `JTM_SLOT_BITS] = pad(samples[i*RES +: RES]);
    end
  end
  // a full-width sample would leave no pad bits, which the pad function cannot build
  if (RES >= `JTM_SLOT_BITS || RES < 1) begin : g_bad_res
    $error("resolution does not fit slot");
  end
endmodule

// *** src/jtm_lane_mapper.sv ***
`timescale 1ns/1ps
`include "jtm_regs.svh"
// Function
// - eight lanes, four on single variant
// - use low lanes, power down rest
// - lane id is index; shared device id
// - mapping depends on link mode
// - tail bits always zero
// - samples sent msb first
// - pad extra low bits with zeros
// - 64b/66b K = 8*32*E/F
// - converter count reported equals lane count
// - mode 0: channel A even/odd lanes 0,1
// - mode 0 quad/dual: channel B lanes 2,3
// - mode 0 quad: channel C lanes 4,5
// - mode 0 quad: channel D lanes 6,7
// - sample index follows conversion time
module jtm_lane_mapper #(
  parameter int RES        = 9,
  parameter int E_BLOCKS   = 1,
  parameter int F_OCTETS   = 8,
  parameter jtm_pkg::jtm_variant_t VARIANT = jtm_pkg::JTM_QUAD
) (
  // clock and reset
  input  wire logic            clk,
  input  wire logic            srst,
  // configuration
  input  wire logic [3:0]      link_mode_select,
  input  wire logic [4:0]      device_id_cfg,
  // sample input: ten samples per channel per frame, index 0 oldest in low bits
  input  wire logic            frame_valid,
  input  wire logic [10*RES-1:0] ch_a,
  input  wire logic [10*RES-1:0] ch_b,
  input  wire logic [10*RES-1:0] ch_c,
  input  wire logic [10*RES-1:0] ch_d,
  output logic                 frame_ready,
  // link-layer octet outputs
  output logic [63:0]          lane_octet,
  output logic                 octet_valid,
  output logic                 frame_start,
  output logic [7:0]           lane_enable,
  output logic [23:0]          lane_id,
  output logic [4:0]           device_id,
  output logic [3:0]           converter_count,
  output logic [8:0]           frames_per_multiframe
);
  localparam int NLANES = (VARIANT == jtm_pkg::JTM_SINGLE) ? 4 : 8;
  localparam int K_FULL = (F_OCTETS < 1) ? 0
                        : (`JTM_K_OCTETS * `JTM_K_BLOCKS * E_BLOCKS) / F_OCTETS;
  localparam logic [8:0] K_66 = 9'(K_FULL);

  // only the 9-bit converter is served here; K must fit its 9-bit field
  if (RES != 9) begin : g_bad_res
    $error("only the 9-bit converter is served");
  end
  if (E_BLOCKS < 1 || F_OCTETS < 1 || K_FULL < 1 || K_FULL > 511) begin : g_bad_k
    $error("bad multiframe parameters");
  end

  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    jtm_pkg::jtm_state_t state;
    logic [2:0]          octet;
    logic [8*64-1:0]     frames;
    logic [7:0]          frame_lanes;
    logic [63:0]         lane_octet;
    logic                octet_valid;
    logic                frame_start;
    logic                frame_ready;
    logic [7:0]          lane_enable;
    logic [23:0]         lane_id;
    logic [4:0]          device_id;
    logic [3:0]          converter_count;
    logic [8:0]          fpmf;
  } jtm_regs_t;

  jtm_regs_t r;
  jtm_regs_t next_r;
  wire logic [8*64-1:0] built;

  ////////////////////////////////////////////////////////////////////////////
  // even samples on the even lane, odd on the odd lane, per channel
  function automatic logic [5*RES-1:0] pick(input logic [10*RES-1:0] ch, input logic odd);
    logic [5*RES-1:0] s;
    s = '0;
    for (int i = 0; i < 5; i++) begin
      s[i*RES +: RES] = ch[(2*i + (odd ? 1 : 0))*RES +: RES];
    end
    return s;
  endfunction

  // lanes counted from zero; anything above the mode's count is powered down
  function automatic logic [7:0] lane_mask(input logic [3:0] n);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < NLANES; i++) begin
      if (4'(i) < n) m[i] = 1'b1;
    end
    return m;
  endfunction

  // lanes a mode needs on this variant; zero means the mode is not built
  function automatic logic [3:0] lanes_for_mode(input logic [3:0] mode);
    logic [3:0] n;
    n = 4'h0;
    if (mode == `JTM_MODE_ZERO) begin
      // dual carries channels a and b only, single carries channel a only
      case (VARIANT)
        jtm_pkg::JTM_QUAD: n = `JTM_LANES_USED_M0;
        jtm_pkg::JTM_DUAL: n = `JTM_LANES_M0_DUAL;
        default:           n = `JTM_LANES_M0_SINGLE;
      endcase
    end
    return n;
  endfunction

  // octet k of a lane frame, octet 0 in the top byte
  function automatic logic [7:0] octet_of(input logic [63:0] f, input logic [2:0] k);
    return f[56 - 8*k +: 8];
  endfunction

  // every lane reports its own physical index
  function automatic logic [23:0] lane_ids();
    logic [23:0] v;
    v = 24'h0;
    for (int i = 0; i < 8; i++) begin
      v[i*3 +: 3] = 3'(i);
    end
    return v;
  endfunction

  logic [5*RES-1:0] lane_src [8];
  always_comb begin
    lane_src[0] = pick(ch_a, 1'b0);
    lane_src[1] = pick(ch_a, 1'b1);
    lane_src[2] = pick(ch_b, 1'b0);
    lane_src[3] = pick(ch_b, 1'b1);
    lane_src[4] = pick(ch_c, 1'b0);
    lane_src[5] = pick(ch_c, 1'b1);
    lane_src[6] = pick(ch_d, 1'b0);
    lane_src[7] = pick(ch_d, 1'b1);
  end

  for (genvar g = 0; g < 8; g++) begin : g_lane
    jtm_lane_frame #(.RES(RES)) u_frame (
      .samples (lane_src[g]),
      .frame   (built[g*64 +: 64])
    );
  end

  ////////////////////////////////////////////////////////////////////////////
  logic [3:0] lanes_needed;
  always_comb begin
    // only mode 0 is built; other codes keep every lane down
    lanes_needed = lanes_for_mode(link_mode_select);
  end

  always_comb begin
    next_r                 = r;
    next_r.octet_valid     = 1'b0;
    next_r.frame_start     = 1'b0;
    next_r.lane_enable     = lane_mask(lanes_needed);
    next_r.device_id       = device_id_cfg;
    next_r.converter_count = lanes_needed;
    next_r.fpmf            = K_66;
    next_r.lane_id         = lane_ids();
    case (r.state)
      jtm_pkg::JTM_IDLE: begin
        next_r.frame_ready = 1'b1;
        if (frame_valid && r.frame_ready && lanes_needed != 4'h0) begin
          next_r.frames      = built;
          // lane set frozen per frame so a mode change cannot cut one lane short
          next_r.frame_lanes = lane_mask(lanes_needed);
          next_r.frame_ready = 1'b0;
          next_r.octet       = `JTM_RST_OCTET;
          next_r.state       = jtm_pkg::JTM_SEND;
        end
      end
      jtm_pkg::JTM_SEND: begin
        // all lanes step through octets together so frame edges stay aligned
        for (int i = 0; i < 8; i++) begin
          if (r.frame_lanes[i]) begin
            next_r.lane_octet[i*8 +: 8] = octet_of(r.frames[i*64 +: 64], r.octet);
          end else begin
            next_r.lane_octet[i*8 +: 8] = `JTM_RST_DATA;
          end
        end
        next_r.octet_valid = 1'b1;
        next_r.frame_start = (r.octet == `JTM_RST_OCTET);
        next_r.octet       = r.octet + 3'h1;
        if (r.octet == 3'(`JTM_FRAME_OCTETS - 1)) begin
          next_r.state       = jtm_pkg::JTM_IDLE;
          next_r.frame_ready = 1'b1;
        end
      end
      default: next_r.state = jtm_pkg::JTM_IDLE;
    endcase
  end

  always_ff @(posedge clk) begin
    if (srst) begin
      r       <= '0;
      r.state <= jtm_pkg::JTM_IDLE;
    end else begin
      r <= next_r;
    end
  end

  // every output comes straight from a state flop
  assign lane_octet            = r.lane_octet;
  assign octet_valid           = r.octet_valid;
  assign frame_start           = r.frame_start;
  assign frame_ready           = r.frame_ready;
  assign lane_enable           = r.lane_enable;
  assign lane_id               = r.lane_id;
  assign device_id             = r.device_id;
  assign converter_count       = r.converter_count;
  assign frames_per_multiframe = r.fpmf;
endmodule

// *** dv/jtm_checker.sv ***
`timescale 1ns/1ps
module jtm_checker #(parameter int E_BLOCKS = 1, parameter int F_OCTETS = 8) (
  // control and handshake
  input wire logic        clk, srst, frame_valid, frame_ready, octet_valid, frame_start,
  // configuration and reported link parameters
  input wire logic [3:0]  link_mode_select, converter_count,
  input wire logic [4:0]  device_id_cfg, device_id,
  input wire logic [7:0]  lane_enable,
  input wire logic [23:0] lane_id,
  input wire logic [8:0]  frames_per_multiframe);
  default clocking @(posedge clk); endclocking
  default disable iff (srst);
  sequence s_burst; octet_valid [*8]; endsequence
  sequence s_busy; !frame_ready [*7] ##1 frame_ready; endsequence
  // the frame is captured at the take, octet 0 shows one edge later
  chk_take_answer: assert property (frame_valid && frame_ready && link_mode_select == 4'h0
    |=> ##1 frame_start) else $error("no start after take");
  chk_start_cause: assert property (frame_start |->
    $past(frame_valid && frame_ready, 2) && $past(link_mode_select, 2) == 4'h0)
    else $error("start without take");
  chk_burst_len: assert property (frame_start |-> s_burst)
    else $error("octet burst short");
  chk_ready_gap: assert property (frame_start |-> s_busy)
    else $error("ready spacing wrong");
  chk_lanes_up: assert property (link_mode_select == 4'h0 |=> lane_enable == 8'hff)
    else $error("lanes not up");
  chk_lanes_down: assert property (link_mode_select != 4'h0
    |=> lane_enable == 8'h00 && converter_count == 4'h0) else $error("lanes not down");
  chk_conv_count: assert property (link_mode_select == 4'h0 |=> converter_count == 4'h8)
    else $error("converter count");
  chk_lane_ids: assert property (!$past(srst)
    |-> lane_id == 24'hfac688 && device_id == $past(device_id_cfg))
    else $error("lane or device id");
  chk_multiframe: assert property (!$past(srst)
    |-> frames_per_multiframe == 9'(8*32*E_BLOCKS/F_OCTETS)) else $error("multiframe count");
endmodule

// *** dv/jtm_rx_model.sv ***
`timescale 1ns/1ps
// far-end receiver, wired from lane 0 upward; passive, it never stalls the link
module jtm_rx_model (
  input wire logic         clk,
  input wire logic [63:0]  lane_octet,
  input wire logic         octet_valid, frame_start,
  output logic     [511:0] rx_frames,
  output int               rx_count);
  logic [2:0] n = 3'h0;
  int         frames_seen = 0;
  assign rx_count = frames_seen;
  always @(posedge clk) if (octet_valid) begin
    for (int l = 0; l < 8; l++)
      rx_frames[64*l+:64] <= {frame_start ? 56'h0 : rx_frames[64*l+:56], lane_octet[8*l+:8]};
    n <= frame_start ? 3'h1 : n + 3'h1;
    if (n == 3'h7) frames_seen <= frames_seen + 1;
  end
endmodule

// *** dv/tb.sv ***
`timescale 1ns/1ps
module tb;
  logic         clk = 0, srst = 1, frame_valid = 0;
  logic [3:0]   link_mode_select = 4'h0;
  logic [4:0]   device_id_cfg = 5'h15;
  logic [89:0]  ch [4];
  logic         frame_ready, octet_valid, frame_start;
  logic [63:0]  lane_octet;
  logic [7:0]   lane_enable;
  logic [23:0]  lane_id;
  logic [4:0]   device_id;
  logic [3:0]   converter_count;
  logic [8:0]   frames_per_multiframe;
  logic [511:0] rx_frames;
  int           rx_count, err_count = 0, total_checks = 0;
  always #25 clk = ~clk;
  jtm_lane_mapper dut_u (.clk, .srst, .link_mode_select, .device_id_cfg, .frame_valid,
    .ch_a(ch[0]), .ch_b(ch[1]), .ch_c(ch[2]), .ch_d(ch[3]), .frame_ready, .lane_octet,
    .octet_valid, .frame_start, .lane_enable, .lane_id, .device_id, .converter_count,
    .frames_per_multiframe);
  jtm_rx_model rx_u (.clk, .lane_octet, .octet_valid, .frame_start, .rx_frames, .rx_count);
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [8:0] smp(int c, int n, int f);
    return (f == 2 && n == 9) ? 9'h1ff : 9'(c * 97 + n * 41 + f * 211 + 5);
  endfunction
  function automatic logic [63:0] exp_lane(int l, int f);
    logic [63:0] e = 64'h0;
    for (int s = 0; s < 5; s++) e[63-12*s-:12] = {smp(l / 2, 2 * s + l % 2, f), 3'h0};
    return e;
  endfunction
  task automatic load(int f);
    for (int c = 0; c < 4; c++) for (int n = 0; n < 10; n++) ch[c][9*n+:9] = smp(c, n, f);
  endtask
  task automatic chk(logic [63:0] got, logic [63:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wt_fs();
    int i = 0;
    @(negedge clk);
    while (frame_start !== 1'b1 && i++ < 30) @(negedge clk);
    chk(frame_start, 1'b1);
  endtask
  task automatic wt_rx(int t);
    int i = 0;
    while (rx_count != t && i++ < 30) @(negedge clk);
    chk(rx_count, t);
  endtask
  task automatic chk_frame(int f);
    for (int l = 0; l < 8; l++)
      chk(rx_frames[64*l+:64], exp_lane(l, f));
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_static();
    chk(lane_enable, 8'hff);
    chk(lane_id, 24'hfac688);
    chk(device_id, device_id_cfg);
    chk(converter_count, 4'h8);
    chk(frames_per_multiframe, 9'h020);
    $display("t_static done");
  endtask
  // frame 2 is offered back to back, so it is taken at the earliest legal edge
  task automatic t_frames();
    int c0 = rx_count;
    load(1);
    frame_valid = 1;
    wt_fs();
    load(2);
    wt_rx(c0 + 1);
    chk_frame(1);
    wt_fs();
    frame_valid = 0;
    wt_rx(c0 + 2);
    chk_frame(2);
    $display("t_frames done");
  endtask
  task automatic t_unmapped();
    link_mode_select = 4'h5;
    frame_valid = 1;
    repeat (12) begin @(negedge clk); chk(octet_valid, 1'b0); end
    chk(lane_enable, 8'h00);
    chk(converter_count, 4'h0);
    frame_valid = 0;
    link_mode_select = 4'h0;
    repeat (2) @(negedge clk);
    chk(lane_enable, 8'hff);
    $display("t_unmapped done");
  endtask
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    load(0);
    repeat (5) @(negedge clk);
    srst = 0;
    repeat (2) @(negedge clk);
    t_static();
    t_frames();
    t_unmapped();
    summarize();
  end
  // the tests need well under 100 cycles; 2000 cycles means a hang
  initial begin
    #100000;
    err_count++;
    summarize();
  end
endmodule
bind jtm_lane_mapper jtm_checker #(.E_BLOCKS(E_BLOCKS), .F_OCTETS(F_OCTETS)) chk_u (.clk,
  .srst, .frame_valid, .frame_ready, .octet_valid, .frame_start, .link_mode_select,
  .converter_count, .device_id_cfg, .device_id, .lane_enable, .lane_id,
  .frames_per_multiframe);
